/* hw/operand_address_and_stack_unit.v */
// Operand effective-address generator and system stack sequencer.
// Assumes stack and program memories answer one cycle after the strobe
// cycle, and that the core presents register contents on regData/pairData.
`include "operand_address_defines.vh"

module operand_address_and_stack_unit (
  input wire core_clk,
  input wire arst_n,
  input wire [9:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire [3:0] avs_byteenable,
  output reg [31:0] avs_readdata,
  output reg avs_waitrequest,
  input wire cmdValid,
  output reg cmdReady,
  input wire [3:0] cmdMode,
  input wire [4:0] cmdClass,
  input wire cmdWide,
  input wire [7:0] cmdField,
  input wire [15:0] cmdWord,
  input wire [15:0] cmdPc,
  input wire [7:0] cmdFlags,
  input wire [7:0] regData,
  input wire [15:0] pairData,
  output reg eaValid,
  output reg [15:0] eaAddr,
  output reg [1:0] eaSpace,
  output reg eaSet2,
  output reg eaFault,
  output reg [7:0] userPtrNext,
  output reg stkWrite,
  output reg stkRead,
  output reg [15:0] stkAddr,
  output reg [7:0] stkWData,
  input wire [7:0] stkRData,
  output reg progRead,
  output reg [15:0] progAddr,
  input wire [15:0] progRData,
  output reg stackDone,
  output reg [15:0] pcOut,
  output reg [7:0] flagsOut
);

  // --------------------------------------------------------------------
  // Sequencer states
  // --------------------------------------------------------------------
  localparam [3:0] S_IDLE = 4'h1;
  localparam [3:0] S_PUSH = 4'h2;
  localparam [3:0] S_RDWT = 4'h4;
  localparam [3:0] S_RDCAP = 4'h8;

  reg [3:0] state;
  reg [7:0] win0;
  reg [7:0] win1;
  reg [15:0] sp;
  reg [23:0] stackQ;
  reg [1:0] stackCnt;
  reg fetching;
  reg popFlags;
  reg [15:0] target;
  reg lastFault;

  // --------------------------------------------------------------------
  // Bus decode
  // --------------------------------------------------------------------
  wire busReq = avs_read | avs_write;
  wire [7:0] busIdx = avs_address[9:2];
  wire busCommit = busReq & ~avs_waitrequest;
  wire busWrite = busCommit & avs_write & avs_byteenable[0];
  wire wrWin0 = busWrite & (busIdx == `REG_WIN0_IDX);
  wire wrWin1 = busWrite & (busIdx == `REG_WIN1_IDX);
  wire wrSpHigh = busWrite & (busIdx == `REG_SP_HIGH_IDX);
  wire wrSpLow = busWrite & (busIdx == `REG_SP_LOW_IDX);
  wire [7:0] busByte = avs_writedata[7:0];

  reg [7:0] rdByte;
  always @* begin
    case (busIdx)
      `REG_WIN0_IDX: rdByte = win0;
      `REG_WIN1_IDX: rdByte = win1;
      `REG_SP_HIGH_IDX: rdByte = sp[15:8];
      `REG_SP_LOW_IDX: rdByte = sp[7:0];
      `REG_STATUS_IDX: rdByte = {6'h00, lastFault, ~state[0]};
      default: rdByte = 8'h00;
    endcase
  end

  // --------------------------------------------------------------------
  // Effective address
  // --------------------------------------------------------------------
  reg [15:0] sext;
  reg [7:0] workAddr;
  reg [7:0] sum8;
  reg [15:0] addr;
  reg [1:0] space;
  reg set2;
  reg fault;
  reg [7:0] ptrNext;
  reg memLoad;
  reg isBranch;
  reg isUser;

  always @* begin
    sext = {{8{cmdField[7]}}, cmdField};
    workAddr = {cmdField[3] ? win1[7:3] : win0[7:3], cmdField[2:0]};
    sum8 = cmdField + regData;
    memLoad = (cmdClass == `CLS_PROG_LOAD) | (cmdClass == `CLS_EXT_LOAD);
    isBranch = (cmdClass == `CLS_BIT_FALSE) | (cmdClass == `CLS_BIT_TRUE) |
               (cmdClass == `CLS_DEC_BRANCH) | (cmdClass == `CLS_CMP_EQ) |
               (cmdClass == `CLS_CMP_NE) | (cmdClass == `CLS_SHORT_JUMP);
    isUser = (cmdClass >= `CLS_USER_PUSH_INC) &
             (cmdClass <= `CLS_USER_POP_DEC);
    addr = 16'h0000;
    space = `SPACE_REGFILE;
    set2 = 1'b0;
    fault = 1'b0;
    ptrNext = regData;
    if (isUser) begin
      case (cmdClass)
        `CLS_USER_PUSH_INC: begin
          ptrNext = regData + 8'h01;
          addr = {8'h00, ptrNext};
        end
        `CLS_USER_PUSH_DEC: begin
          ptrNext = regData - 8'h01;
          addr = {8'h00, ptrNext};
        end
        `CLS_USER_POP_INC: begin
          ptrNext = regData + 8'h01;
          addr = {8'h00, regData};
        end
        default: begin
          ptrNext = regData - 8'h01;
          addr = {8'h00, regData};
        end
      endcase
    end else begin
      case (cmdMode)
        `MODE_REG: begin
          if (cmdField[7:4] == `WORK_PREFIX)
            addr = {8'h00, workAddr};
          else
            addr = {8'h00, cmdField};
          if (cmdWide)
            addr[0] = 1'b0;
        end
        `MODE_PTR: begin
          if (cmdWide) begin
            addr = pairData;
            space = (cmdClass == `CLS_EXT_LOAD) ? `SPACE_EXTERNAL :
                    `SPACE_PROGRAM;
          end else begin
            addr = {8'h00, regData};
            set2 = regData >= `SET2_BASE;
          end
        end
        `MODE_IDX_REG: begin
          addr = {8'h00, sum8};
          set2 = sum8 >= `SET2_BASE;
          fault = cmdClass != `CLS_LOAD;
        end
        `MODE_IDX_SHORT, `MODE_IDX_LONG: begin
          if (cmdMode == `MODE_IDX_SHORT)
            addr = pairData + sext;
          else
            addr = pairData + cmdWord;
          space = (cmdClass == `CLS_EXT_LOAD) ? `SPACE_EXTERNAL :
                  `SPACE_PROGRAM;
          fault = ~memLoad;
        end
        `MODE_ABS: begin
          addr = cmdWord;
          space = (cmdClass == `CLS_EXT_LOAD) ? `SPACE_EXTERNAL :
                  `SPACE_PROGRAM;
        end
        `MODE_VEC: begin
          addr = {8'h00, cmdField};
          space = `SPACE_PROGRAM;
          fault = cmdClass != `CLS_CALL;
        end
        `MODE_PCOFF: begin
          addr = cmdPc + sext;
          space = `SPACE_PROGRAM;
          fault = ~isBranch;
        end
        `MODE_LIT: begin
          addr = cmdWide ? cmdWord : {8'h00, cmdField};
          space = `SPACE_LITERAL;
        end
        default: fault = 1'b1;
      endcase
    end
  end

  // --------------------------------------------------------------------
  // Command acceptance
  // --------------------------------------------------------------------
  wire cmdTake = cmdValid & cmdReady;
  wire seqClass = (cmdClass == `CLS_CALL) | (cmdClass == `CLS_RET) |
                  (cmdClass == `CLS_INT) | (cmdClass == `CLS_RETURN_FROM_INTERRUPT);
  wire startSeq = cmdTake & seqClass & ~fault;
  wire nextIdle = state[0] & ~startSeq;
  wire next_cmdReady = nextIdle & ~(avs_waitrequest & busReq);
  wire [23:0] popQ = {stackQ[15:0], stkRData};
  // Stack arithmetic is a full 16-bit count, so a low byte wrap spills into
  // the high byte; software avoids this by starting low at FF.
  wire [15:0] spDec = sp - 16'h0001;
  wire [15:0] spInc = sp + 16'h0001;

  // --------------------------------------------------------------------
  // Register slave
  // --------------------------------------------------------------------
  // One wait cycle per access; held off while the stack sequencer runs so
  // software never races a push or pop on the stack pointer.
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h00000000;
      cmdReady <= 1'b0;
      win0 <= `WIN0_RESET;
      win1 <= `WIN1_RESET;
    end else begin
      cmdReady <= next_cmdReady;
      if (!avs_waitrequest) begin
        avs_waitrequest <= 1'b1;
      end else if (busReq && nextIdle) begin
        avs_waitrequest <= 1'b0;
        avs_readdata <= {24'h000000, rdByte};
      end
      if (wrWin0)
        win0 <= busByte;
      if (wrWin1)
        win1 <= busByte;
    end
  end

  // --------------------------------------------------------------------
  // Address results and stack sequencer
  // --------------------------------------------------------------------
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      state <= S_IDLE;
      sp <= `SP_RESET;
      stackQ <= 24'h000000;
      stackCnt <= 2'h0;
      fetching <= 1'b0;
      popFlags <= 1'b0;
      target <= 16'h0000;
      lastFault <= 1'b0;
      eaValid <= 1'b0;
      eaAddr <= 16'h0000;
      eaSpace <= `SPACE_REGFILE;
      eaSet2 <= 1'b0;
      eaFault <= 1'b0;
      userPtrNext <= 8'h00;
      stkWrite <= 1'b0;
      stkRead <= 1'b0;
      stkAddr <= 16'h0000;
      stkWData <= 8'h00;
      progRead <= 1'b0;
      progAddr <= 16'h0000;
      stackDone <= 1'b0;
      pcOut <= 16'h0000;
      flagsOut <= 8'h00;
    end else begin
      eaValid <= cmdTake;
      stkWrite <= 1'b0;
      stkRead <= 1'b0;
      progRead <= 1'b0;
      stackDone <= 1'b0;
      if (wrSpHigh)
        sp[15:8] <= busByte;
      if (wrSpLow)
        sp[7:0] <= busByte;
      if (cmdTake) begin
        eaAddr <= addr;
        eaSpace <= space;
        eaSet2 <= set2;
        eaFault <= fault;
        userPtrNext <= ptrNext;
        lastFault <= fault;
      end
      case (state)
        S_IDLE: begin
          if (startSeq) begin
            target <= (cmdClass == `CLS_INT) ? cmdWord : addr;
            fetching <= 1'b0;
            popFlags <= cmdClass == `CLS_RETURN_FROM_INTERRUPT;
            case (cmdClass)
              `CLS_CALL: begin
                stackQ <= {8'h00, cmdPc[15:8], cmdPc[7:0]};
                stackCnt <= 2'h2;
                if (cmdMode == `MODE_VEC) begin
                  fetching <= 1'b1;
                  progRead <= 1'b1;
                  progAddr <= {8'h00, cmdField};
                  state <= S_RDWT;
                end else begin
                  state <= S_PUSH;
                end
              end
              `CLS_INT: begin
                stackQ <= {cmdFlags, cmdPc[15:8], cmdPc[7:0]};
                stackCnt <= 2'h3;
                state <= S_PUSH;
              end
              default: begin
                stackCnt <= (cmdClass == `CLS_RETURN_FROM_INTERRUPT) ? 2'h3 : 2'h2;
                stkRead <= 1'b1;
                stkAddr <= sp;
                state <= S_RDWT;
              end
            endcase
          end
        end
        S_PUSH: begin
          sp <= spDec;
          stkAddr <= spDec;
          stkWrite <= 1'b1;
          stkWData <= stackQ[7:0];
          stackQ <= {8'h00, stackQ[23:8]};
          stackCnt <= stackCnt - 2'h1;
          if (stackCnt == 2'h1) begin
            stackDone <= 1'b1;
            pcOut <= target;
            state <= S_IDLE;
          end
        end
        S_RDWT: begin
          state <= S_RDCAP;
        end
        S_RDCAP: begin
          if (fetching) begin
            fetching <= 1'b0;
            target <= progRData;
            state <= S_PUSH;
          end else begin
            stackQ <= popQ;
            sp <= spInc;
            stackCnt <= stackCnt - 2'h1;
            if (stackCnt == 2'h1) begin
              stackDone <= 1'b1;
              pcOut <= popQ[15:0];
              if (popFlags)
                flagsOut <= popQ[23:16];
              state <= S_IDLE;
            end else begin
              stkRead <= 1'b1;
              stkAddr <= spInc;
              state <= S_RDWT;
            end
          end
        end
        default: state <= S_IDLE;
      endcase
    end
  end

endmodule

/* shared/operand_address_defines.vh */
// Constants shared by the operand address and stack unit.
// Assumes a byte-addressed Avalon-MM slave with one 32-bit word per index.
`ifndef OPERAND_ADDRESS_DEFINES_VH
`define OPERAND_ADDRESS_DEFINES_VH

// ----------------------------------------------------------------------
// Register indexes (byte address is four times the index)
// ----------------------------------------------------------------------
`define REG_WIN0_IDX 8'hd6
`define REG_WIN1_IDX 8'hd7
`define REG_SP_HIGH_IDX 8'hd8
`define REG_SP_LOW_IDX 8'hd9
`define REG_STATUS_IDX 8'hda

// ----------------------------------------------------------------------
// Reset values and field positions
// ----------------------------------------------------------------------
`define WIN0_RESET 8'hc0
`define WIN1_RESET 8'hc8
`define SP_RESET 16'h0000
`define WORK_PREFIX 4'hc
`define SET2_BASE 8'hc0
`define STATUS_BUSY_BIT 0
`define STATUS_FAULT_BIT 1

// ----------------------------------------------------------------------
// Addressing modes
// ----------------------------------------------------------------------
`define MODE_REG 4'h0
`define MODE_PTR 4'h1
`define MODE_IDX_REG 4'h2
`define MODE_IDX_SHORT 4'h3
`define MODE_IDX_LONG 4'h4
`define MODE_ABS 4'h5
`define MODE_VEC 4'h6
`define MODE_PCOFF 4'h7
`define MODE_LIT 4'h8

// ----------------------------------------------------------------------
// Instruction classes
// ----------------------------------------------------------------------
`define CLS_OTHER 5'h00
`define CLS_LOAD 5'h01
`define CLS_PROG_LOAD 5'h02
`define CLS_EXT_LOAD 5'h03
`define CLS_JUMP 5'h04
`define CLS_CALL 5'h05
`define CLS_RET 5'h06
`define CLS_INT 5'h07
`define CLS_RETURN_FROM_INTERRUPT 5'h08
`define CLS_BIT_FALSE 5'h09
`define CLS_BIT_TRUE 5'h0a
`define CLS_DEC_BRANCH 5'h0b
`define CLS_CMP_EQ 5'h0c
`define CLS_CMP_NE 5'h0d
`define CLS_SHORT_JUMP 5'h0e
`define CLS_USER_PUSH_INC 5'h0f
`define CLS_USER_PUSH_DEC 5'h10
`define CLS_USER_POP_INC 5'h11
`define CLS_USER_POP_DEC 5'h12

// ----------------------------------------------------------------------
// Operand spaces
// ----------------------------------------------------------------------
`define SPACE_REGFILE 2'h0
`define SPACE_PROGRAM 2'h1
`define SPACE_EXTERNAL 2'h2
`define SPACE_LITERAL 2'h3

`endif

/* testbench/oasu_checker_assertions.sv */
// Concurrent checks on the operand address and stack unit.
// Sees only top-level ports; bound from tb_top.
`include "operand_address_defines.vh"
module oasu_checker (
  input logic core_clk,
  input logic arst_n,
  input logic cmdValid,
  input logic cmdReady,
  input logic [3:0] cmdMode,
  input logic [4:0] cmdClass,
  input logic cmdWide,
  input logic [7:0] cmdField,
  input logic [15:0] cmdWord,
  input logic [15:0] cmdPc,
  input logic [15:0] pairData,
  input logic [15:0] eaAddr,
  input logic eaFault,
  input logic stkWrite,
  input logic [15:0] stkAddr,
  input logic stackDone,
  input logic [15:0] pcOut
);
  timeunit 1ns;
  timeprecision 1ps;
  wire take = cmdValid && cmdReady;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  // ---------------------------------------------------------------
  // Address forming
  // ---------------------------------------------------------------
  chk_work_low_bits: assert property (
    take && cmdMode == `MODE_REG && cmdField[7:4] == 4'hc && !cmdWide
    |=> eaAddr[2:0] == $past(cmdField[2:0])) else $error("work bits");
  chk_abs_target: assert property (
    take && cmdMode == `MODE_ABS && cmdClass == `CLS_EXT_LOAD
    |=> eaAddr == $past(cmdWord)) else $error("absolute address");
  chk_rel_target: assert property (
    take && cmdMode == `MODE_PCOFF && cmdClass == `CLS_SHORT_JUMP
    |=> eaAddr == $past(cmdPc) + {{8{$past(cmdField[7])}},
    $past(cmdField)}) else $error("relative target");
  chk_vec_refused: assert property (
    take && cmdMode == `MODE_VEC && cmdClass != `CLS_CALL
    |=> eaFault && !stkWrite) else $error("vector not refused");
  chk_short_index: assert property (
    take && cmdMode == `MODE_IDX_SHORT && cmdClass == `CLS_PROG_LOAD
    |=> eaAddr == $past(pairData) + {{8{$past(cmdField[7])}},
    $past(cmdField)}) else $error("short index");
  // ---------------------------------------------------------------
  // Stack sequencing
  // ---------------------------------------------------------------
  chk_push_predec: assert property (
    stkWrite && $past(stkWrite) |-> stkAddr == $past(stkAddr) - 16'h1)
    else $error("push address step");
  chk_call_done: assert property (
    take && cmdClass == `CLS_CALL && cmdMode == `MODE_ABS
    |-> ##3 stackDone && pcOut == $past(cmdWord, 3)) else $error("call");
  chk_ret_done: assert property (
    take && cmdClass == `CLS_RET |=> !stackDone [*4] ##1 stackDone)
    else $error("return timing");
  chk_int_done: assert property (
    take && cmdClass == `CLS_INT
    |-> ##4 stackDone && pcOut == $past(cmdWord, 4)) else $error("int");
  cover property (take && cmdClass == `CLS_RETURN_FROM_INTERRUPT);
  cover property (take && cmdClass == `CLS_CALL);
  cover property (take ##1 eaFault);
endmodule

/* testbench/tb_top.sv */
// Self-checking bench for the operand address and stack unit.
// Acts as bus master, core and stack/program memories itself.
`include "operand_address_defines.vh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk, arst_n, avs_read, avs_write, cmdValid, cmdWide;
  logic [9:0] avs_address;
  logic [31:0] avs_writedata;
  logic [3:0] avs_byteenable, cmdMode;
  logic [4:0] cmdClass;
  logic [7:0] cmdField, cmdFlags, regData, rd;
  logic [15:0] cmdWord, cmdPc, pairData;
  logic [7:0] stkRData = 8'h00;
  logic [15:0] progRData = 16'h0000;
  wire [31:0] avs_readdata;
  wire avs_waitrequest, cmdReady, eaValid, eaSet2, eaFault, stkWrite;
  wire stkRead, progRead, stackDone;
  wire [15:0] eaAddr, stkAddr, progAddr, pcOut;
  wire [1:0] eaSpace;
  wire [7:0] userPtrNext, stkWData, flagsOut;
  logic [7:0] mem [256];
  logic [4:0] br [6] = '{`CLS_BIT_FALSE, `CLS_BIT_TRUE, `CLS_DEC_BRANCH,
    `CLS_CMP_EQ, `CLS_CMP_NE, `CLS_SHORT_JUMP};
  logic [4:0] uc [4] = '{`CLS_USER_PUSH_INC, `CLS_USER_PUSH_DEC,
    `CLS_USER_POP_INC, `CLS_USER_POP_DEC};
  logic [7:0] un [4] = '{8'h41, 8'h3f, 8'h41, 8'h3f};
  logic [7:0] ua [4] = '{8'h41, 8'h3f, 8'h40, 8'h40};
  int err_count = 0;
  int compares = 0;
  operand_address_and_stack_unit dut (.core_clk(core_clk),
    .arst_n(arst_n), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .cmdValid(cmdValid),
    .cmdReady(cmdReady), .cmdMode(cmdMode), .cmdClass(cmdClass),
    .cmdWide(cmdWide), .cmdField(cmdField), .cmdWord(cmdWord),
    .cmdPc(cmdPc), .cmdFlags(cmdFlags), .regData(regData),
    .pairData(pairData), .eaValid(eaValid), .eaAddr(eaAddr),
    .eaSpace(eaSpace), .eaSet2(eaSet2), .eaFault(eaFault),
    .userPtrNext(userPtrNext), .stkWrite(stkWrite), .stkRead(stkRead),
    .stkAddr(stkAddr), .stkWData(stkWData), .stkRData(stkRData),
    .progRead(progRead), .progAddr(progAddr), .progRData(progRData),
    .stackDone(stackDone), .pcOut(pcOut), .flagsOut(flagsOut));
  initial begin
    core_clk = 0;
    forever #5 core_clk = ~core_clk;
  end
  // ---------------------------------------------------------------
  // Memories: read data lands in the cycle after the strobe
  // ---------------------------------------------------------------
  always @(posedge core_clk) begin
    if (stkWrite) mem[stkAddr[7:0]] <= stkWData;
    if (stkRead) stkRData <= mem[stkAddr[7:0]];
    if (progRead) progRData <= 16'h3000 | progAddr;
  end
  task automatic report_and_stop();
    if (err_count == 0 && compares > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input string n, input logic [15:0] e, g);
    compares++;
    if (g !== e) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  function automatic logic sig(int k);
    case (k)
      0: return !avs_waitrequest;
      1: return cmdReady;
      2: return eaValid;
      default: return stackDone;
    endcase
  endfunction
  // Bounded wait; samples at the edge, before that edge's updates land
  task automatic wait_on(int k);
    int n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (sig(k) !== 1'b1 && n < 60);
    if (n >= 60) begin
      err_count++;
      report_and_stop();
    end
  endtask
  task automatic bus(input logic wr, input logic [9:0] a, input logic [7:0] d);
    @(posedge core_clk);
    avs_address <= a;
    avs_writedata <= {24'h0, d};
    avs_write <= wr;
    avs_read <= !wr;
    wait_on(0);
    rd = avs_readdata[7:0];
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  task automatic cmd(input logic [3:0] m, input logic [4:0] c, input logic w,
      input logic [7:0] f, input logic [15:0] wd);
    @(posedge core_clk);
    cmdMode <= m;
    cmdClass <= c;
    cmdWide <= w;
    cmdField <= f;
    cmdWord <= wd;
    cmdValid <= 1'b1;
    wait_on(1);
    cmdValid <= 1'b0;
    wait_on(2);
    // One more edge so the last stack write has landed in the memory model
    if (c inside {`CLS_CALL, `CLS_RET, `CLS_INT, `CLS_RETURN_FROM_INTERRUPT}) begin
      wait_on(3);
      @(posedge core_clk);
    end
  endtask
  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    {arst_n, avs_read, avs_write, cmdValid, cmdWide} = '0;
    {avs_address, avs_writedata, cmdMode, cmdClass, cmdField} = '0;
    {cmdFlags, regData, cmdWord, cmdPc, pairData} = '0;
    avs_byteenable = 4'hf;
    repeat (8) @(posedge core_clk);
    arst_n <= 1'b1;
    bus(0, 10'h358, 0); chk("window0", 8'hc0, rd);
    bus(0, 10'h35c, 0); chk("window1", 8'hc8, rd);
    bus(0, 10'h000, 0); chk("unmapped", 0, rd);
    bus(1, 10'h35c, 8'ha8);
    cmd(`MODE_REG, `CLS_LOAD, 0, 8'hcb, 0); chk("rp1", 16'hab, eaAddr);
    cmd(`MODE_REG, `CLS_LOAD, 0, 8'hc3, 0); chk("rp0", 16'hc3, eaAddr);
    cmd(`MODE_REG, `CLS_LOAD, 1, 8'h35, 0); chk("pair", 16'h34, eaAddr);
    regData <= 8'hd0;
    cmd(`MODE_PTR, `CLS_LOAD, 0, 8'h10, 0); chk("ptr", 16'hd0, eaAddr);
    chk("ptr set", 1, eaSet2);
    pairData <= 16'h1234;
    cmd(`MODE_PTR, `CLS_PROG_LOAD, 1, 0, 0); chk("pr", 16'h1234, eaAddr);
    regData <= 8'h05;
    cmd(`MODE_IDX_REG, `CLS_LOAD, 0, 8'hc0, 0); chk("x", 16'hc5, eaAddr);
    chk("idx set", 1, eaSet2);
    cmd(`MODE_IDX_REG, `CLS_PROG_LOAD, 0, 8'h10, 0); chk("xc", 1, eaFault);
    pairData <= 16'h1000;
    cmd(`MODE_IDX_SHORT, `CLS_PROG_LOAD, 0, 8'h80, 0);
    chk("short", 16'h0f80, eaAddr);
    cmd(`MODE_IDX_LONG, `CLS_EXT_LOAD, 0, 0, 16'h0123);
    chk("long", 16'h1123, eaAddr);
    cmd(`MODE_IDX_LONG, `CLS_LOAD, 0, 0, 16'h0123); chk("lc", 1, eaFault);
    cmd(`MODE_ABS, `CLS_EXT_LOAD, 0, 0, 16'hbeef);
    chk("abs", 16'hbeef, eaAddr);
    cmd(`MODE_VEC, `CLS_JUMP, 0, 8'h20, 0); chk("vj", 1, eaFault);
    bus(0, 10'h368, 0); chk("status", 8'h02, rd);
    cmd(`MODE_LIT, `CLS_LOAD, 1, 8'h5a, 16'h7788);
    chk("lit", `SPACE_LITERAL, eaSpace);
    cmdPc <= 16'h0200;
    foreach (br[i]) begin
      cmd(`MODE_PCOFF, br[i], 0, 8'hfe, 0); chk("rel", 16'h01fe, eaAddr);
      chk("rel ok", 0, eaFault);
    end
    cmd(`MODE_PCOFF, `CLS_LOAD, 0, 8'h7f, 0); chk("rc", 1, eaFault);
    regData <= 8'h40;
    foreach (uc[i]) begin
      cmd(`MODE_REG, uc[i], 0, 0, 0); chk("uptr", un[i], userPtrNext);
      chk("uaddr", ua[i], eaAddr[7:0]);
    end
    bus(1, 10'h360, 8'h00);
    bus(1, 10'h364, 8'hff);
    bus(0, 10'h360, 0); chk("sp high", 0, rd);
    cmdPc <= 16'h1234;
    cmd(`MODE_ABS, `CLS_CALL, 0, 0, 16'h4000); chk("c", 16'h4000, pcOut);
    chk("push lo", 8'h34, mem[8'hfe]);
    chk("push hi", 8'h12, mem[8'hfd]);
    bus(0, 10'h364, 0); chk("sp call", 8'hfd, rd);
    cmd(`MODE_REG, `CLS_RET, 0, 0, 0); chk("ret", 16'h1234, pcOut);
    bus(0, 10'h364, 0); chk("sp ret", 8'hff, rd);
    cmdPc <= 16'h2345;
    cmdFlags <= 8'h5a;
    cmd(`MODE_ABS, `CLS_INT, 0, 0, 16'h0100); chk("i", 16'h0100, pcOut);
    chk("push fl", 8'h5a, mem[8'hfc]);
    cmdPc <= 16'h0000;
    cmdFlags <= 8'h00;
    cmd(`MODE_REG, `CLS_RETURN_FROM_INTERRUPT, 0, 0, 0); chk("return_from_interrupt", 16'h2345, pcOut);
    chk("return_from_interrupt fl", 8'h5a, flagsOut);
    bus(1, 10'h360, 8'h11);
    bus(1, 10'h364, 8'h00);
    cmd(`MODE_ABS, `CLS_CALL, 0, 0, 16'h0000);
    bus(0, 10'h360, 0); chk("borrow", 8'h10, rd);
    cmd(`MODE_REG, `CLS_RET, 0, 0, 0);
    bus(0, 10'h360, 0); chk("carry", 8'h11, rd);
    cmd(`MODE_VEC, `CLS_CALL, 0, 8'h20, 0); chk("v", 16'h3020, pcOut);
    avs_byteenable <= 4'he;
    bus(1, 10'h358, 8'h11);
    avs_byteenable <= 4'hf;
    bus(0, 10'h358, 0); chk("be off", 8'hc0, rd);
    report_and_stop();
  end
endmodule
bind operand_address_and_stack_unit oasu_checker chk_i (
  .core_clk(core_clk), .arst_n(arst_n), .cmdValid(cmdValid),
  .cmdReady(cmdReady), .cmdMode(cmdMode), .cmdClass(cmdClass),
  .cmdWide(cmdWide), .cmdField(cmdField), .cmdWord(cmdWord),
  .cmdPc(cmdPc), .pairData(pairData), .eaAddr(eaAddr),
  .eaFault(eaFault), .stkWrite(stkWrite), .stkAddr(stkAddr),
  .stackDone(stackDone), .pcOut(pcOut));
